// ### hw/axis_status.sv
// per-axis trajectory status flags, refreshed each sample period
`timescale 1ns/1ns
module axis_status
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sample_tick,
	input wire logic [7:0] traj_start,
	input wire logic [7:0][31:0] pos_delta,
	input wire logic [7:0][31:0] axis_vel,
	input wire logic [7:0] move_busy,
	input wire logic [7:0] kill_stop,
	input wire logic [7:0] ferr_trip,
	input wire logic [7:0] motor_enable,
	input wire logic [31:0] runstop_thr,
	input wire logic [31:0] vel_thr,
	output logic [7:0] running,
	output logic [7:0] motor_off,
	output logic [7:0] vel_above,
	output logic [7:0] move_done
);
	// run and velocity flags, once per sample period
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			running <= 8'h00;
			vel_above <= 8'h00;
		end
		else if (sample_tick)
		begin
			for (int a = 0; a < traj_pkg::AXES; a++)
			begin
				running[a] <= traj_pkg::mag32(pos_delta[a]) > runstop_thr;
				vel_above[a] <= traj_pkg::mag32(axis_vel[a]) > vel_thr;
			end
		end
	end

	// motor off latches on kill or trip; set beats enable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			motor_off <= 8'h00;
		else
		begin
			for (int a = 0; a < traj_pkg::AXES; a++)
			begin
				if (sample_tick && (kill_stop[a] || ferr_trip[a]))
					motor_off[a] <= 1'b1;
				else if (motor_enable[a])
					motor_off[a] <= 1'b0;
			end
		end
	end

	// move complete: true when idle, false from the start event on
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			move_done <= traj_pkg::MOVE_DONE_RST;
		else
		begin
			for (int a = 0; a < traj_pkg::AXES; a++)
			begin
				if (traj_start[a])
					move_done[a] <= 1'b0;
				else if (sample_tick)
					move_done[a] <= !move_busy[a];
			end
		end
	end
endmodule

// ### hw/sample_fifo.sv
// word fifo holding captured position and velocity samples
`timescale 1ns/1ns
module sample_fifo
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire logic push_valid,
	output logic push_ready,
	input wire logic [31:0] push_data,
	output logic pop_valid,
	input wire logic pop_ready,
	output logic [31:0] pop_data,
	output logic [8:0] count
);
	logic [31:0] mem [traj_pkg::FIFO_DEPTH]; // sample words
	logic [7:0] wr_reg; // write pointer
	logic [7:0] rd_reg; // read pointer
	logic [8:0] cnt_reg; // words held
	logic do_push;
	logic do_pop;

	// honest full and empty
	assign push_ready = cnt_reg != 9'(traj_pkg::FIFO_DEPTH);
	assign pop_valid = cnt_reg != 9'h000;
	assign do_push = push_valid && push_ready;
	assign do_pop = pop_valid && pop_ready;
	assign pop_data = mem[rd_reg];
	assign count = cnt_reg;

	// storage, no reset needed
	always_ff @(posedge pclk)
	begin
		if (do_push)
			mem[wr_reg] <= push_data;
	end

	// pointers and fill level
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_reg <= 8'h00;
			rd_reg <= 8'h00;
			cnt_reg <= 9'h000;
		end
		else if (clear)
		begin
			wr_reg <= 8'h00;
			rd_reg <= 8'h00;
			cnt_reg <= 9'h000;
		end
		else
		begin
			if (do_push)
				wr_reg <= wr_reg + 8'h01;
			if (do_pop)
				rd_reg <= rd_reg + 8'h01;
			cnt_reg <= cnt_reg + 9'(do_push) - 9'(do_pop);
		end
	end
endmodule

// ### hw/traj_pkg.sv
// shared constants, types and helpers of the trajectory readback block
package traj_pkg;
	localparam int AXES = 8;
	localparam int VSPACES = 4;
	localparam int NVARS = 120;
	localparam int FIFO_DEPTH = 256;
	localparam int HOST_WORDS = 16;
	// register byte offsets
	localparam logic [11:0] CMD_OFS = 12'h000;
	localparam logic [11:0] STAT_OFS = 12'h004;
	localparam logic [11:0] MCS_OFS = 12'h008;
	localparam logic [11:0] RUNTHR_OFS = 12'h00c;
	localparam logic [11:0] VELTHR_OFS = 12'h010;
	localparam logic [11:0] INHEN_OFS = 12'h014;
	localparam logic [11:0] CAPCFG_OFS = 12'h018;
	localparam logic [11:0] VSPACE_OFS = 12'h01c;
	localparam logic [11:0] FLAGS_OFS = 12'h020;
	localparam logic [11:0] PEND_BASE = 12'h040;
	localparam logic [11:0] HOST_BASE = 12'h080;
	localparam logic [11:0] VAR_BASE = 12'h400;
	// command word fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_AXIS_LSB = 2;
	localparam int CMD_STYPE_LSB = 5;
	localparam int CMD_VEC_BIT = 7;
	localparam int CMD_DEST_LSB = 8;
	// status register fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ERR_BIT = 1;
	localparam int STAT_CAP_BIT = 2;
	localparam int STAT_CNT_LSB = 4;
	localparam int STAT_WORDS_LSB = 16;
	// destination codes
	localparam logic [7:0] DEST_NONE = 8'h00;
	localparam logic [7:0] DEST_HOST = 8'hff;
	localparam logic [7:0] DVAR_HI = 8'h78;
	localparam logic [7:0] IVAR_LO = 8'h81;
	localparam logic [7:0] IVAR_HI = 8'hf8;
	// reset values
	localparam logic [7:0] MOVE_DONE_RST = 8'hff;
	localparam logic [31:0] THR_RST = 32'h0000_0000;
	typedef enum logic [1:0] {OP_TARGET, OP_SAMPLE, OP_STATUS, OP_SPARE} op_e;
	typedef enum logic [1:0] {ST_RUN, ST_OFF, ST_VEL, ST_DONE} stype_e;
	typedef enum logic [2:0] {D_NONE, D_HOST, D_DVAR, D_IVAR, D_BAD} dest_e;
	// class of a destination code
	function automatic dest_e dest_kind(input logic [7:0] c);
		if (c == DEST_NONE)
			return D_NONE;
		if (c == DEST_HOST)
			return D_HOST;
		if (c <= DVAR_HI)
			return D_DVAR;
		if (c >= IVAR_LO && c <= IVAR_HI)
			return D_IVAR;
		return D_BAD;
	endfunction
	// magnitude of a signed word
	function automatic logic [31:0] mag32(input logic [31:0] v);
		return v[31] ? 32'(-v) : v;
	endfunction
endpackage

// ### hw/traj_readback.sv
// readback engine: target latch, sample fifo, status maps, apb slave
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
module traj_readback
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] traj_start,
	input wire logic [7:0] traj_blend,
	input wire logic sample_tick,
	input wire logic [7:0][31:0] axis_pos,
	input wire logic [7:0][31:0] axis_vel,
	input wire logic [7:0][31:0] pos_delta,
	input wire logic [7:0] move_busy,
	input wire logic [7:0] kill_stop,
	input wire logic [7:0] ferr_trip,
	input wire logic [7:0] motor_enable,
	output logic [7:0] inhibit_out
);
	typedef enum logic [1:0] {ENG_IDLE, ENG_RESOLVE, ENG_CHECK, ENG_EMIT} eng_e;

	// software registers
	logic [31:0] runthr_reg; // run/stop threshold
	logic [31:0] velthr_reg; // velocity threshold
	logic [7:0] inhen_reg; // inhibit enables
	logic [31:0] vspace_reg; // four 8-bit member masks
	logic [31:0] capcfg_reg; // mask, interval, count
	logic [31:0] pend_reg [traj_pkg::AXES]; // loaded targets
	logic [31:0] act_reg [traj_pkg::AXES]; // readable targets
	logic [31:0] var_mem [traj_pkg::NVARS]; // onboard variables
	logic [31:0] host_mem [traj_pkg::HOST_WORDS]; // host results
	// engine state
	eng_e state_reg;
	traj_pkg::op_e op_reg;
	logic [2:0] axis_reg;
	traj_pkg::stype_e stype_reg;
	logic vec_reg;
	logic [7:0] dest_reg;
	logic [7:0] base_reg; // first variable index
	logic [4:0] widx_reg; // word being emitted
	logic [4:0] nwords_reg;
	logic [4:0] words_reg; // words in last host result
	logic err_reg;
	// capture state
	logic cap_reg; // capture running
	logic [7:0] ivl_reg; // periods to next sample
	logic [15:0] left_reg; // samples still to take
	logic walk_reg; // pushing a sample
	logic [3:0] slot_reg; // word slot 0..15
	logic [31:0] snap_reg [16]; // latched sample
	// bus strobes
	logic wr_en;
	logic setup;
	logic addr_ok;
	logic [31:0] rd_word;
	logic cmd_take;
	// status flags
	logic [7:0] running;
	logic [7:0] motor_off;
	logic [7:0] vel_above;
	logic [7:0] move_done;
	logic [3:0] vs_done;
	logic [7:0] status_map;
	// fifo wiring
	logic push_valid;
	logic push_ready;
	logic pop_valid;
	logic pop_ready;
	logic [31:0] pop_data;
	logic [8:0] fifo_cnt;
	logic fifo_clear;
	// engine helpers
	traj_pkg::dest_e kind;
	logic [7:0] ptr;
	logic [7:0] base_next;
	logic res_err;
	logic [4:0] need;
	logic chk_err;
	logic [31:0] emit_word;
	logic [7:0] var_idx;

	// zero-wait slave; access phase always completes
	assign pready = 1'b1;
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite && addr_ok;
	assign pslverr = psel && penable && !addr_ok;
	assign cmd_take = wr_en && paddr == traj_pkg::CMD_OFS && state_reg == ENG_IDLE;

	// address decode
	always_comb
	begin
		addr_ok = paddr[1:0] == 2'b00;
		if (paddr >= traj_pkg::VAR_BASE)
			addr_ok = addr_ok && paddr < traj_pkg::VAR_BASE + 12'(4 * traj_pkg::NVARS);
		else if (paddr >= traj_pkg::HOST_BASE)
			addr_ok = addr_ok && paddr < traj_pkg::HOST_BASE + 12'(4 * traj_pkg::HOST_WORDS);
		else if (paddr >= traj_pkg::PEND_BASE)
			addr_ok = addr_ok && paddr < traj_pkg::PEND_BASE + 12'(4 * traj_pkg::AXES);
		else
			addr_ok = addr_ok && paddr <= traj_pkg::FLAGS_OFS;
	end

	// read mux
	always_comb
	begin
		rd_word = 32'h0000_0000;
		if (paddr >= traj_pkg::VAR_BASE)
			rd_word = var_mem[7'((paddr - traj_pkg::VAR_BASE) >> 2)];
		else if (paddr >= traj_pkg::HOST_BASE)
			rd_word = host_mem[4'((paddr - traj_pkg::HOST_BASE) >> 2)];
		else if (paddr >= traj_pkg::PEND_BASE)
			rd_word = pend_reg[3'((paddr - traj_pkg::PEND_BASE) >> 2)];
		else
		begin
			unique case (paddr)
				traj_pkg::STAT_OFS:
				begin
					rd_word[traj_pkg::STAT_BUSY_BIT] = state_reg != ENG_IDLE;
					rd_word[traj_pkg::STAT_ERR_BIT] = err_reg;
					rd_word[traj_pkg::STAT_CAP_BIT] = cap_reg;
					rd_word[traj_pkg::STAT_CNT_LSB +: 9] = fifo_cnt;
					rd_word[traj_pkg::STAT_WORDS_LSB +: 5] = words_reg;
				end
				traj_pkg::MCS_OFS: rd_word[7:0] = move_done;
				traj_pkg::RUNTHR_OFS: rd_word = runthr_reg;
				traj_pkg::VELTHR_OFS: rd_word = velthr_reg;
				traj_pkg::INHEN_OFS: rd_word[7:0] = inhen_reg;
				traj_pkg::CAPCFG_OFS: rd_word = capcfg_reg;
				traj_pkg::VSPACE_OFS: rd_word = vspace_reg;
				traj_pkg::FLAGS_OFS: rd_word = {8'h00, vel_above, motor_off, running};
				default: rd_word = 32'h0000_0000;
			endcase
		end
	end

	// read data captured in the setup cycle; refused addresses read as zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup && !pwrite)
			prdata <= addr_ok ? rd_word : 32'h0000_0000;
	end

	// plain configuration registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			runthr_reg <= traj_pkg::THR_RST;
			velthr_reg <= traj_pkg::THR_RST;
			inhen_reg <= 8'h00;
			vspace_reg <= 32'h0000_0000;
		end
		else if (wr_en)
		begin
			unique case (paddr)
				traj_pkg::RUNTHR_OFS: runthr_reg <= pwdata;
				traj_pkg::VELTHR_OFS: velthr_reg <= pwdata;
				traj_pkg::INHEN_OFS: inhen_reg <= pwdata[7:0];
				traj_pkg::VSPACE_OFS: vspace_reg <= pwdata;
				default: ;
			endcase
		end
	end

	// pending targets from software, active copy on start or blend
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int a = 0; a < traj_pkg::AXES; a++)
			begin
				pend_reg[a] <= 32'h0000_0000;
				act_reg[a] <= 32'h0000_0000;
			end
		end
		else
		begin
			for (int a = 0; a < traj_pkg::AXES; a++)
			begin
				if (wr_en && paddr == traj_pkg::PEND_BASE + 12'(4 * a))
					pend_reg[a] <= pwdata;
				if (traj_start[a] || traj_blend[a])
					act_reg[a] <= pend_reg[a];
			end
		end
	end

	// capture config write restarts capture
	assign fifo_clear = wr_en && paddr == traj_pkg::CAPCFG_OFS;

	// capture timing: interval and sample count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			capcfg_reg <= 32'h0000_0000;
			cap_reg <= 1'b0;
			ivl_reg <= 8'h00;
			left_reg <= 16'h0000;
		end
		else if (fifo_clear)
		begin
			capcfg_reg <= pwdata;
			cap_reg <= pwdata[31:16] != 16'h0000 && pwdata[7:0] != 8'h00;
			ivl_reg <= 8'h00;
			left_reg <= pwdata[31:16];
		end
		else if (sample_tick && cap_reg && !walk_reg)
		begin
			if (ivl_reg == 8'h00)
			begin
				ivl_reg <= capcfg_reg[15:8];
				left_reg <= left_reg - 16'h0001;
				cap_reg <= left_reg != 16'h0001;
			end
			else
				ivl_reg <= ivl_reg - 8'h01;
		end
	end

	// sample snapshot and word walk, stalled by a full fifo
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			walk_reg <= 1'b0;
			slot_reg <= 4'h0;
			for (int s = 0; s < 16; s++)
				snap_reg[s] <= 32'h0000_0000;
		end
		else if (fifo_clear)
			walk_reg <= 1'b0;
		else if (sample_tick && cap_reg && !walk_reg && ivl_reg == 8'h00)
		begin
			walk_reg <= 1'b1;
			slot_reg <= 4'h0;
			for (int a = 0; a < traj_pkg::AXES; a++)
			begin
				snap_reg[2 * a] <= axis_pos[a];
				snap_reg[2 * a + 1] <= axis_vel[a];
			end
		end
		else if (walk_reg && (push_ready || !push_valid))
		begin
			slot_reg <= slot_reg + 4'h1;
			walk_reg <= slot_reg != 4'hf;
		end
	end

	// only slots of chosen axes enter the fifo, ascending
	assign push_valid = walk_reg && capcfg_reg[slot_reg[3:1]];

	sample_fifo u_fifo
	(
		.pclk(pclk),
		.presetn(presetn),
		.clear(fifo_clear),
		.push_valid(push_valid),
		.push_ready(push_ready),
		.push_data(snap_reg[slot_reg]),
		.pop_valid(pop_valid),
		.pop_ready(pop_ready),
		.pop_data(pop_data),
		.count(fifo_cnt)
	);

	axis_status u_status
	(
		.pclk(pclk),
		.presetn(presetn),
		.sample_tick(sample_tick),
		.traj_start(traj_start),
		.pos_delta(pos_delta),
		.axis_vel(axis_vel),
		.move_busy(move_busy),
		.kill_stop(kill_stop),
		.ferr_trip(ferr_trip),
		.motor_enable(motor_enable),
		.runstop_thr(runthr_reg),
		.vel_thr(velthr_reg),
		.running(running),
		.motor_off(motor_off),
		.vel_above(vel_above),
		.move_done(move_done)
	);

	// inhibit follows motor off where enabled
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			inhibit_out <= 8'h00;
		else
			inhibit_out <= motor_off & inhen_reg;
	end

	// vector space complete is the and of its members
	always_comb
	begin
		for (int v = 0; v < traj_pkg::VSPACES; v++)
			vs_done[v] = &(move_done | ~vspace_reg[8 * v +: 8]);
	end

	// selected status bitmap
	always_comb
	begin
		unique case (stype_reg)
			traj_pkg::ST_RUN: status_map = running;
			traj_pkg::ST_OFF: status_map = motor_off;
			traj_pkg::ST_VEL: status_map = vel_above;
			traj_pkg::ST_DONE: status_map = vec_reg ? {4'h0, vs_done} : move_done;
		endcase
	end

	// destination resolution and admission checks
	always_comb
	begin
		kind = traj_pkg::dest_kind(dest_reg);
		ptr = var_mem[7'(dest_reg[6:0] - 7'h01)][7:0];
		base_next = 8'h00;
		res_err = 1'b0;
		unique case (kind)
			traj_pkg::D_DVAR: base_next = dest_reg - 8'h01;
			traj_pkg::D_IVAR:
			begin
				base_next = ptr - 8'h01;
				res_err = ptr == 8'h00 || ptr > traj_pkg::DVAR_HI;
			end
			traj_pkg::D_BAD: res_err = 1'b1;
			default: base_next = 8'h00;
		endcase
		need = 5'h01;
		if (op_reg == traj_pkg::OP_SAMPLE)
			need = 5'($countones(capcfg_reg[7:0])) << 1;
		chk_err = 1'b0;
		if (op_reg == traj_pkg::OP_SAMPLE)
			chk_err = need == 5'h00 || fifo_cnt < 9'(need);
		if (op_reg == traj_pkg::OP_STATUS && vec_reg)
			chk_err = stype_reg != traj_pkg::ST_DONE || axis_reg >= 3'(traj_pkg::VSPACES);
		if (op_reg == traj_pkg::OP_SPARE)
			chk_err = 1'b1;
		if (kind == traj_pkg::D_DVAR || kind == traj_pkg::D_IVAR)
			chk_err = chk_err || 9'(base_reg) + 9'(need) > 9'(traj_pkg::NVARS);
	end

	// word being emitted and its variable slot
	always_comb
	begin
		unique case (op_reg)
			traj_pkg::OP_TARGET: emit_word = act_reg[axis_reg];
			traj_pkg::OP_SAMPLE: emit_word = pop_data;
			default: emit_word = {24'h00_0000, status_map};
		endcase
	end
	assign var_idx = base_reg + 8'(widx_reg);
	assign pop_ready = state_reg == ENG_EMIT && op_reg == traj_pkg::OP_SAMPLE;

	// command engine
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= ENG_IDLE;
			op_reg <= traj_pkg::OP_TARGET;
			axis_reg <= 3'h0;
			stype_reg <= traj_pkg::ST_RUN;
			vec_reg <= 1'b0;
			dest_reg <= 8'h00;
			base_reg <= 8'h00;
			widx_reg <= 5'h00;
			nwords_reg <= 5'h00;
		end
		else
		begin
			unique case (state_reg)
				ENG_IDLE:
					if (cmd_take)
					begin
						op_reg <= traj_pkg::op_e'(pwdata[traj_pkg::CMD_OP_LSB +: 2]);
						axis_reg <= pwdata[traj_pkg::CMD_AXIS_LSB +: 3];
						stype_reg <= traj_pkg::stype_e'(pwdata[traj_pkg::CMD_STYPE_LSB +: 2]);
						vec_reg <= pwdata[traj_pkg::CMD_VEC_BIT];
						dest_reg <= pwdata[traj_pkg::CMD_DEST_LSB +: 8];
						state_reg <= ENG_RESOLVE;
					end
				ENG_RESOLVE:
				begin
					base_reg <= base_next;
					state_reg <= res_err ? ENG_IDLE : ENG_CHECK;
				end
				ENG_CHECK:
				begin
					nwords_reg <= need;
					widx_reg <= 5'h00;
					state_reg <= chk_err ? ENG_IDLE : ENG_EMIT;
				end
				ENG_EMIT:
				begin
					widx_reg <= widx_reg + 5'h01;
					if (widx_reg == nwords_reg - 5'h01)
						state_reg <= ENG_IDLE;
				end
			endcase
		end
	end

	// error flag: engine set wins over software clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			err_reg <= 1'b0;
		else if ((state_reg == ENG_RESOLVE && res_err) || (state_reg == ENG_CHECK && chk_err))
			err_reg <= 1'b1;
		else if (cmd_take)
			err_reg <= 1'b0;
		else if (wr_en && paddr == traj_pkg::STAT_OFS && pwdata[traj_pkg::STAT_ERR_BIT])
			err_reg <= 1'b0;
	end

	// host result words and count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			words_reg <= 5'h00;
			for (int i = 0; i < traj_pkg::HOST_WORDS; i++)
				host_mem[i] <= 32'h0000_0000;
		end
		else if (state_reg == ENG_CHECK && !chk_err && dest_reg == traj_pkg::DEST_HOST)
			words_reg <= need;
		else if (state_reg == ENG_EMIT && dest_reg == traj_pkg::DEST_HOST)
			host_mem[widx_reg[3:0]] <= emit_word;
	end

	// onboard variables: engine beats software
	always_ff @(posedge pclk)
	begin
		if (state_reg == ENG_EMIT && (traj_pkg::dest_kind(dest_reg) == traj_pkg::D_DVAR
			|| traj_pkg::dest_kind(dest_reg) == traj_pkg::D_IVAR))
			var_mem[7'(var_idx)] <= emit_word;
		else if (wr_en && paddr >= traj_pkg::VAR_BASE)
			var_mem[7'((paddr - traj_pkg::VAR_BASE) >> 2)] <= pwdata;
	end
endmodule

// ### verification/apb_host.sv
// host model: apb master issuing register transfers
`timescale 1ns/1ns
module apb_host
(
	input wire logic pclk,
	input wire logic pready,
	input wire logic [31:0] prdata,
	output logic [11:0] paddr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [31:0] pwdata
);
	// bus idle at time zero
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end
	// one transfer: setup, access until pready, release
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// ### verification/traj_readback_sva.sv
// bus-level checker for the trajectory readback block
`timescale 1ns/1ns
module traj_readback_sva
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// zero wait states always
	a_ready_high: assert property (pready) else $error("pready low");
	// error only inside an access phase
	a_err_phase: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
	// misaligned word refused
	a_err_misalign: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("misaligned access accepted");
	// command word always mapped
	a_cmd_mapped: assert property (psel && penable && paddr == traj_pkg::CMD_OFS |-> !pslverr)
		else $error("command word refused");
	// variable window mapped
	a_var_mapped: assert property (psel && penable && paddr >= traj_pkg::VAR_BASE
		&& paddr < 12'h05e0 && paddr[1:0] == 2'b00 |-> !pslverr) else $error("variable refused");
	// done bitmap holds eight bits only
	a_done_width: assert property (psel && !penable && !pwrite
		&& paddr == traj_pkg::MCS_OFS |=> prdata[31:8] == 24'h00_0000) else $error("done width");
	// flags packed one bit per axis
	a_flags_width: assert property (psel && !penable && !pwrite
		&& paddr == traj_pkg::FLAGS_OFS |=> prdata[31:24] == 8'h00) else $error("flags width");
	// refused read returns zero
	a_bad_zero: assert property (psel && !penable && !pwrite && paddr[1:0] != 2'b00
		|=> prdata == 32'h0000_0000) else $error("refused read not zero");
	// read data held outside setup
	a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("prdata moved");
endmodule
bind traj_readback traj_readback_sva traj_readback_sva_inst (.pclk(pclk), .presetn(presetn),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
	.pready(pready), .pslverr(pslverr));

// ### verification/traj_readback_tb.sv
// self-checking bench for the trajectory readback block
`timescale 1ns/1ns
module traj_readback_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_tick;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0] traj_start, traj_blend, move_busy, kill_stop, ferr_trip, motor_enable, inhibit_out;
	logic [7:0][31:0] axis_pos, axis_vel, pos_delta;
	int mismatches = 0, tests_run = 0, cycles = 0;
	logic [7:0] smap [4] = '{8'h01, 8'h48, 8'h20, 8'hfd};
	logic [31:0] sexp [4] = '{32'h0000_0100, 32'h0000_0011, 32'h0000_0300, 32'h0000_0033};
	traj_readback traj_readback_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .traj_start(traj_start), .traj_blend(traj_blend),
		.sample_tick(sample_tick), .axis_pos(axis_pos), .axis_vel(axis_vel),
		.pos_delta(pos_delta), .move_busy(move_busy), .kill_stop(kill_stop),
		.ferr_trip(ferr_trip), .motor_enable(motor_enable), .inhibit_out(inhibit_out));
	apb_host apb_host_inst (.pclk(pclk), .pready(pready), .prdata(prdata), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata));
	// compare one word
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb_host_inst.xfer(1'b1, a, d, q);
	endtask
	// read and compare
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		apb_host_inst.xfer(1'b0, a, 32'h0000_0000, q);
		chk(q, exp);
	endtask
	// issue command, poll busy, check error bit
	task automatic cmd(input logic [15:0] c, input logic e);
		logic [31:0] q;
		int n;
		wr(traj_pkg::CMD_OFS, {16'h0000, c});
		n = 0;
		q = 32'h0000_0001;
		while (q[0] !== 1'b0 && n < 100)
		begin
			apb_host_inst.xfer(1'b0, traj_pkg::STAT_OFS, 32'h0000_0000, q);
			n++;
		end
		chk({30'h0, q[1:0]}, {30'h0, e, 1'b0});
	endtask
	// one-cycle event: 0 start, 1 blend, 2 tick; then settle capture
	task automatic ev(input int w, input logic [7:0] m);
		@(posedge pclk);
		if (w == 0)
			traj_start <= m;
		else if (w == 1)
			traj_blend <= m;
		else
			sample_tick <= m[0];
		@(posedge pclk);
		traj_start <= 8'h00;
		traj_blend <= 8'h00;
		sample_tick <= 1'b0;
		repeat (20) @(posedge pclk);
	endtask
	task automatic close_out();
		if (mismatches == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// clock
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// hang guard
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			close_out();
		end
	end
	// main sequence
	initial
	begin
		{presetn, sample_tick, traj_start, traj_blend, move_busy, kill_stop} = '0;
		{ferr_trip, motor_enable, axis_pos, axis_vel, pos_delta} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rdc(traj_pkg::MCS_OFS, 32'h0000_00ff);
		wr(traj_pkg::RUNTHR_OFS, 32'h0000_0010);
		wr(traj_pkg::VELTHR_OFS, 32'h0000_0040);
		pos_delta[0] <= 32'h0000_0020;
		axis_vel[5] <= 32'h0000_0050;
		kill_stop <= 8'h08;
		ferr_trip <= 8'h40;
		move_busy <= 8'h02;
		ev(2, 8'h01);
		kill_stop <= 8'h00;
		ferr_trip <= 8'h00;
		for (int s = 0; s < 4; s++)
		begin
			cmd(16'hff02 | 16'(s << 5), 1'b0);
			rdc(traj_pkg::HOST_BASE, {24'h0, smap[s]});
		end
		rdc(traj_pkg::FLAGS_OFS, 32'h0020_4801);
		wr(traj_pkg::INHEN_OFS, 32'h0000_0008);
		repeat (2) @(posedge pclk);
		chk({24'h0, inhibit_out}, 32'h0000_0008);
		wr(traj_pkg::VSPACE_OFS, 32'h0000_0003);
		cmd(16'hffe2, 1'b0);
		rdc(traj_pkg::HOST_BASE, 32'h0000_000e);
		cmd(16'hff82, 1'b1);
		axis_pos[2] <= 32'h0000_0777;
		wr(traj_pkg::PEND_BASE + 12'h008, 32'h0000_1234);
		cmd(16'hff08, 1'b0);
		rdc(traj_pkg::HOST_BASE, 32'h0000_0000);
		ev(0, 8'h04);
		cmd(16'hff08, 1'b0);
		rdc(traj_pkg::HOST_BASE, 32'h0000_1234);
		wr(traj_pkg::PEND_BASE + 12'h008, 32'h0000_5678);
		cmd(16'hff08, 1'b0);
		rdc(traj_pkg::HOST_BASE, 32'h0000_1234);
		ev(1, 8'h04);
		cmd(16'hff08, 1'b0);
		rdc(traj_pkg::HOST_BASE, 32'h0000_5678);
		wr(traj_pkg::VAR_BASE + 12'h010, 32'h0000_0002);
		cmd(16'h8508, 1'b0);
		rdc(traj_pkg::VAR_BASE + 12'h004, 32'h0000_5678);
		cmd(16'h0308, 1'b0);
		rdc(traj_pkg::VAR_BASE + 12'h008, 32'h0000_5678);
		cmd(16'h0008, 1'b0);
		cmd(16'h7908, 1'b1);
		rdc(12'h3fc, 32'h0000_0000);
		rdc(12'h00e, 32'h0000_0000);
		rdc(traj_pkg::VAR_BASE + 12'h006, 32'h0000_0000);
		axis_pos[0] <= 32'h0000_0100;
		axis_vel[0] <= 32'h0000_0011;
		axis_pos[2] <= 32'h0000_0300;
		axis_vel[2] <= 32'h0000_0033;
		wr(traj_pkg::CAPCFG_OFS, 32'h0002_0005);
		ev(2, 8'h01);
		axis_pos[0] <= 32'h0000_0101;
		ev(2, 8'h01);
		cmd(16'h0101, 1'b0);
		for (int k = 0; k < 4; k++)
			rdc(traj_pkg::VAR_BASE + 12'(4 * k), sexp[k]);
		cmd(16'hff01, 1'b0);
		rdc(traj_pkg::HOST_BASE, 32'h0000_0101);
		cmd(16'hff01, 1'b1);
		close_out();
	end
endmodule
